// ===== design/vscale_consts.svh
// timing, field and reset constants for the one-pin voltage scaling link
`ifndef VSCALE_CONSTS_SVH
`define VSCALE_CONSTS_SVH

// ----------------------------------------------------------------------
// clock and time figures
// ----------------------------------------------------------------------
`define CLK_MHZ           125
`define MODE_TIMEOUT_US   520
`define STARTUP_US        170
`define STREAM_CLOSE_NS   2000
`define START_HOLD_NS     2000
`define ACK_VALID_NS      4000
`define ACK_PULSE_US      400
`define SW_FREQ_KHZ       2250

// ----------------------------------------------------------------------
// derived cycle counts (least times round up, longest round down)
// ----------------------------------------------------------------------
`define MODE_TIMEOUT_CYC  (`MODE_TIMEOUT_US * `CLK_MHZ)
`define STARTUP_CYC       (`STARTUP_US * `CLK_MHZ)
`define STREAM_CLOSE_CYC  ((`STREAM_CLOSE_NS * `CLK_MHZ + 999) / 1000)
`define START_HOLD_CYC    ((`START_HOLD_NS * `CLK_MHZ + 999) / 1000)
`define ACK_VALID_CYC     ((`ACK_VALID_NS * `CLK_MHZ + 999) / 1000)
`define ACK_PULSE_CYC     (`ACK_PULSE_US * `CLK_MHZ)
`define SW_PERIOD_CYC     ((`CLK_MHZ * 1000) / `SW_FREQ_KHZ)
`define SOFT_START_CYC    2000

// ----------------------------------------------------------------------
// widths, field positions and reset values
// ----------------------------------------------------------------------
`define MEAS_W            17
`define BYTE_BITS         8
`define DATA_ACK_BIT      7
`define DATA_SEL_HI       6
`define DATA_SEL_LO       5
`define SETTING_W         5
`define SETTING1_RESET    5'h00
`define SETTING2_RESET    5'h00

`endif

// ===== design/vscale_pkg.sv
// types shared by the voltage scaling link modules
`include "vscale_consts.svh"
package vscale_pkg;
  // receiver sequence states
  typedef enum logic [2:0]
  {
    S_IDLE  = 3'b000,
    S_ADDR  = 3'b001,
    S_DATA  = 3'b010,
    S_CLOSE = 3'b011,
    S_ACK   = 3'b100
  } rx_state_e;
  // register-select codes of the data byte
  typedef enum logic [1:0]
  {
    SEL_CONV1 = 2'b00,
    SEL_ALT1  = 2'b01,
    SEL_CONV2 = 2'b10,
    SEL_RSVD  = 2'b11
  } reg_select_e;
  // duration counter word
  typedef logic [`MEAS_W-1:0] meas_t;
endpackage

// ===== design/bit_meas_if.sv
// measurement results passed from the bit decoder to the link core
`timescale 1ns/10ps
interface bit_meas_if;
  logic seg_done;     // falling edge closed a measured interval
  logic seg_one;      // high at least twice low
  logic seg_zero;     // low at least twice high
  logic close_ok;     // low part long enough to close a byte
  logic start_ok;     // high part long enough for a start
  logic low_timeout;  // line held low for the mode delay
  modport decoder (output seg_done, seg_one, seg_zero, close_ok, start_ok, low_timeout);
  modport core    (input  seg_done, seg_one, seg_zero, close_ok, start_ok, low_timeout);
endinterface

// ===== design/pulse_ratio_decoder.sv
// falling-edge to falling-edge duty ratio bit decoder
`timescale 1ns/10ps
`include "vscale_consts.svh"
module pulse_ratio_decoder
  import vscale_pkg::*;
#(
  parameter int TIMEOUT_CYC = `MODE_TIMEOUT_CYC,
  parameter int CLOSE_CYC   = `STREAM_CLOSE_CYC,
  parameter int START_CYC   = `START_HOLD_CYC
)
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // control and line level (already synchronised)
  input  wire logic enable,
  input  wire logic line,
  // results
  bit_meas_if.decoder m
);

  // ----------------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------------
  if (TIMEOUT_CYC < 2 || TIMEOUT_CYC >= (1 << `MEAS_W))
  begin : g_bad_timeout
    $error("timeout does not fit the duration counter");
  end

  logic  line_q;    // previous line level
  logic  armed;     // a falling edge opened an interval
  meas_t low_cnt;   // cycles low in current interval
  meas_t high_cnt;  // cycles high in current interval
  logic  fall;      // falling edge seen this cycle

  assign fall = line_q & ~line;

  // ----------------------------------------------------------------------
  // edge history
  // ----------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      line_q <= 1'b1;
    else
      line_q <= line;
  end

  // ----------------------------------------------------------------------
  // duration counters, restarted on every falling edge
  // ----------------------------------------------------------------------
  // the low counter runs even when not armed so the mode delay also
  // elapses after the line was simply pulled down from idle
  always_ff @(posedge clk)
  begin
    if (!rst_n || !enable)
    begin
      armed    <= 1'b0;
      low_cnt  <= '0;
      high_cnt <= '0;
    end
    else if (fall)
    begin
      armed    <= 1'b1;
      low_cnt  <= meas_t'(1);
      high_cnt <= '0;
    end
    else if (!line)
    begin
      if (low_cnt == meas_t'(TIMEOUT_CYC - 1))
        armed <= 1'b0;                   // long low ends any bit stream
      if (low_cnt != meas_t'(TIMEOUT_CYC))
        low_cnt <= low_cnt + meas_t'(1);
    end
    else if (high_cnt != '1)
      high_cnt <= high_cnt + meas_t'(1); // saturate on long idle high
  end

  // ----------------------------------------------------------------------
  // ratio decision, reported one cycle after the closing edge
  // ----------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n || !enable)
    begin
      m.seg_done    <= 1'b0;
      m.seg_one     <= 1'b0;
      m.seg_zero    <= 1'b0;
      m.close_ok    <= 1'b0;
      m.start_ok    <= 1'b0;
      m.low_timeout <= 1'b0;
    end
    else
    begin
      m.seg_done    <= fall & armed;
      m.seg_one     <= ({1'b0, high_cnt} >= {low_cnt, 1'b0}) && (high_cnt != '0);
      m.seg_zero    <= ({1'b0, low_cnt} >= {high_cnt, 1'b0}) && (low_cnt != '0);
      m.close_ok    <= low_cnt >= meas_t'(CLOSE_CYC);
      m.start_ok    <= high_cnt >= meas_t'(START_CYC);
      m.low_timeout <= !line && (low_cnt == meas_t'(TIMEOUT_CYC - 1));
    end
  end

endmodule

// ===== design/one_pin_vout_scaling_link.sv
// control logic of the dual step-down converter with one-pin setting link
`timescale 1ns/10ps
`include "vscale_consts.svh"
module one_pin_vout_scaling_link
  import vscale_pkg::*;
#(
  parameter logic [7:0]           OWN_ADDRESS      = 8'h5A, // arbitrary value
  parameter int                   MODE_TIMEOUT_CYC = `MODE_TIMEOUT_CYC,
  parameter int                   STARTUP_CYC      = `STARTUP_CYC,
  parameter int                   ACK_PULSE_CYC    = `ACK_PULSE_CYC,
  parameter int                   SOFT_START_CYC   = `SOFT_START_CYC,
  parameter logic [`SETTING_W-1:0] SETTING1_DEFAULT = `SETTING1_RESET,
  parameter logic [`SETTING_W-1:0] SETTING2_DEFAULT = `SETTING2_RESET
)
(
  // clock and reset
  input  wire logic                  MCLK,
  input  wire logic                  RESET_N,
  // shared mode/data pin, open drain
  input  wire logic                  MODE_DATA_IN,
  output logic                       MODE_DATA_OUT,
  output logic                       MODE_DATA_OE_N,
  // converter enables and supervisors
  input  wire logic                  CONVERTER1_ENABLE,
  input  wire logic                  CONVERTER2_ENABLE,
  input  wire logic                  UNDER_VOLTAGE,
  input  wire logic                  OVER_TEMP,
  // per-converter analog comparators, index 0 is converter 1
  input  wire logic [1:0]            HS_LIMIT,
  input  wire logic [1:0]            LS_LIMIT,
  input  wire logic [1:0]            PWM_TRIP,
  input  wire logic [1:0]            LIGHT_LOAD,
  // power switch gates
  output logic [1:0]                 HS_ON,
  output logic [1:0]                 LS_ON,
  // converter status
  output logic [1:0]                 SOFT_START,
  output logic                       POWER_SAVE,
  output logic                       RX_READY,
  // voltage settings
  output logic [`SETTING_W-1:0]      CONVERTER1_VOLTAGE_SETTING,
  output logic [`SETTING_W-1:0]      CONVERTER2_VOLTAGE_SETTING
);

  // ----------------------------------------------------------------------
  // elaboration checks and local constants
  // ----------------------------------------------------------------------
  localparam int NSYNC     = 13;
  localparam int CLOSE_CYC = `STREAM_CLOSE_CYC;
  localparam int VALID_CYC = `ACK_VALID_CYC;
  localparam int PERIOD    = `SW_PERIOD_CYC;

  if (VALID_CYC <= CLOSE_CYC || ACK_PULSE_CYC < 1 || STARTUP_CYC < 1 ||
      ACK_PULSE_CYC >= (1 << `MEAS_W) || STARTUP_CYC >= (1 << `MEAS_W) ||
      SOFT_START_CYC < 1 || SOFT_START_CYC >= (1 << `MEAS_W))
  begin : g_bad_counts
    $error("timing counts cannot be served by the counters");
  end

  // ----------------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------------
  logic [NSYNC-1:0] sync1;    // first stage, read by sync2 only
  logic [NSYNC-1:0] sync2;    // stable copies
  logic             line;     // mode/data level
  logic             ot;       // over-temperature
  logic             uvlo;     // supply below lockout
  logic [1:0]       en;       // converter enables
  logic [1:0]       ls_lim;   // low-side over limit
  logic [1:0]       hs_lim;   // high-side over limit
  logic [1:0]       trip;     // regulation comparator ends on-time
  logic [1:0]       light;    // light load seen

  // all comparator and pin levels are asynchronous to the clock
  always_ff @(posedge MCLK)
  begin
    if (!RESET_N)
    begin
      sync1 <= {1'b1, {(NSYNC-1){1'b0}}}; // pin idles high, so no false fall
      sync2 <= {1'b1, {(NSYNC-1){1'b0}}};
    end
    else
    begin
      sync1 <= {MODE_DATA_IN, OVER_TEMP, UNDER_VOLTAGE, CONVERTER2_ENABLE,
                CONVERTER1_ENABLE, LS_LIMIT, HS_LIMIT, PWM_TRIP, LIGHT_LOAD};
      sync2 <= sync1;
    end
  end

  assign {line, ot, uvlo, en, ls_lim, hs_lim, trip, light} = sync2;

  // ----------------------------------------------------------------------
  // shutdown and receiver startup
  // ----------------------------------------------------------------------
  logic  active;     // some converter enabled, supply good
  meas_t start_cnt;  // startup delay counter

  assign active = (en[0] | en[1]) & ~uvlo;

  // counter restarts each time the part leaves shutdown
  always_ff @(posedge MCLK)
  begin
    if (!RESET_N || !active)
    begin
      start_cnt <= '0;
      RX_READY  <= 1'b0;
    end
    else if (start_cnt != meas_t'(STARTUP_CYC - 1))
      start_cnt <= start_cnt + meas_t'(1);
    else
      RX_READY  <= 1'b1;
  end

  // ----------------------------------------------------------------------
  // bit decoder
  // ----------------------------------------------------------------------
  bit_meas_if meas ();
  rx_state_e  state;     // receiver sequence
  logic       dec_en;    // decoder listens to the line

  // decoder is deaf while a byte closes or our own ack pulls the line
  assign dec_en = active && (state != S_CLOSE) && (state != S_ACK);

  pulse_ratio_decoder #(
    .TIMEOUT_CYC (MODE_TIMEOUT_CYC),
    .CLOSE_CYC   (CLOSE_CYC),
    .START_CYC   (`START_HOLD_CYC)
  ) u_decoder (
    .clk    (MCLK),
    .rst_n  (RESET_N),
    .enable (dec_en),
    .line   (line),
    .m      (meas.decoder)
  );

  // ----------------------------------------------------------------------
  // receiver sequence
  // ----------------------------------------------------------------------
  logic [3:0]  bit_cnt;   // bits taken in current byte
  logic [7:0]  shreg;     // incoming byte, msb first
  logic [7:0]  addr_q;    // captured address byte
  logic        bad;       // some bit or delimiter was malformed
  meas_t       wait_cnt;  // cycles since last falling edge / ack start
  logic [1:0]  sel;       // register select of data byte
  logic        good;      // transaction fit for a write
  logic        commit;    // write strobe

  assign sel    = {shreg[`DATA_SEL_HI], shreg[`DATA_SEL_LO]};
  assign good   = !bad && (addr_q == OWN_ADDRESS) &&
                  (sel == SEL_CONV1 || sel == SEL_CONV2);
  assign commit = (state == S_CLOSE) && !line && good &&
                  (wait_cnt == meas_t'(CLOSE_CYC - 1));

  always_ff @(posedge MCLK)
  begin
    if (!RESET_N || !RX_READY)
    begin
      state          <= S_IDLE;
      bit_cnt        <= '0;
      shreg          <= '0;
      addr_q         <= '0;
      bad            <= 1'b0;
      wait_cnt       <= '0;
      MODE_DATA_OE_N <= 1'b1;
    end
    else
    begin
      case (state)
        S_IDLE:
        begin
          // first measured interval is the first address bit
          if (meas.seg_done)
          begin
            shreg   <= {shreg[6:0], meas.seg_one};
            bit_cnt <= 4'h1;
            bad     <= ~(meas.seg_one | meas.seg_zero);
            state   <= S_ADDR;
          end
        end
        S_ADDR, S_DATA:
        begin
          if (meas.low_timeout)
            state <= S_IDLE;                  // stream abandoned
          else if (meas.seg_done && bit_cnt < 4'(`BYTE_BITS))
          begin
            shreg   <= {shreg[6:0], meas.seg_one};
            bit_cnt <= bit_cnt + 4'h1;
            bad     <= bad | ~(meas.seg_one | meas.seg_zero);
            if (state == S_DATA && bit_cnt == 4'(`BYTE_BITS - 1))
            begin
              wait_cnt <= '0;
              state    <= S_CLOSE;            // 16th bit done
            end
          end
          else if (meas.seg_done)
          begin
            // interval after the address byte is close plus start
            bad     <= bad | ~(meas.close_ok & meas.start_ok);
            addr_q  <= shreg;
            bit_cnt <= '0;
            state   <= S_DATA;
          end
        end
        S_CLOSE:
        begin
          wait_cnt <= wait_cnt + meas_t'(1);
          if (line && wait_cnt < meas_t'(CLOSE_CYC))
            state <= S_IDLE;                  // not correctly terminated
          else if (wait_cnt == meas_t'(CLOSE_CYC - 1) &&
                   !(good && shreg[`DATA_ACK_BIT]))
            state <= S_IDLE;
          else if (wait_cnt == meas_t'(VALID_CYC - 1))
          begin
            wait_cnt       <= '0;
            MODE_DATA_OE_N <= 1'b0;           // pull the line low
            state          <= S_ACK;
          end
        end
        S_ACK:
        begin
          wait_cnt <= wait_cnt + meas_t'(1);
          if (wait_cnt == meas_t'(ACK_PULSE_CYC - 1))
          begin
            MODE_DATA_OE_N <= 1'b1;           // release after bounded pulse
            state          <= S_IDLE;
          end
        end
        default:
          state <= S_IDLE;
      endcase
    end
  end

  // driven level is always low; the enable alone makes the pulse
  always_ff @(posedge MCLK)
  begin
    MODE_DATA_OUT <= 1'b0;
  end

  // ----------------------------------------------------------------------
  // voltage setting registers
  // ----------------------------------------------------------------------
  // only reset and lockout reload them; shutdown keeps written values
  always_ff @(posedge MCLK)
  begin
    if (!RESET_N || uvlo)
    begin
      CONVERTER1_VOLTAGE_SETTING <= SETTING1_DEFAULT;
      CONVERTER2_VOLTAGE_SETTING <= SETTING2_DEFAULT;
    end
    else if (commit && sel == SEL_CONV1)
      CONVERTER1_VOLTAGE_SETTING <= shreg[`SETTING_W-1:0];
    else if (commit && sel == SEL_CONV2)
      CONVERTER2_VOLTAGE_SETTING <= shreg[`SETTING_W-1:0];
  end

  // ----------------------------------------------------------------------
  // operating mode
  // ----------------------------------------------------------------------
  logic ps_armed;  // timeout seen since line went low

  always_ff @(posedge MCLK)
  begin
    if (!RESET_N || line)
      ps_armed <= 1'b0;
    else if (meas.low_timeout)
      ps_armed <= 1'b1;
  end

  // reception keeps forced PWM even while the line is low
  always_ff @(posedge MCLK)
  begin
    if (!RESET_N)
      POWER_SAVE <= 1'b0;
    else
      POWER_SAVE <= ps_armed && !line && (state == S_IDLE);
  end

  // ----------------------------------------------------------------------
  // switching phase, one shared period for both converters
  // ----------------------------------------------------------------------
  logic [7:0] phase;  // position in switching period

  always_ff @(posedge MCLK)
  begin
    if (!RESET_N || !active)
      phase <= '0;
    else if (phase == 8'(PERIOD - 1))
      phase <= '0;
    else
      phase <= phase + 8'h01;
  end

  // ----------------------------------------------------------------------
  // per-converter switch control
  // ----------------------------------------------------------------------
  for (genvar i = 0; i < 2; i++)
  begin : g_conv
    logic  run;       // converter allowed to switch
    logic  hold;      // high side barred after current limit
    logic  skip;      // pulse skipping at light load
    logic  start;     // turn-on instant of this converter
    logic  next_hs;   // high side next cycle
    meas_t ss_cnt;    // soft start progress

    assign run   = active & en[i] & ~ot;
    assign skip  = POWER_SAVE & light[i];
    assign start = (phase == 8'(i * (PERIOD / 2)));

    // limit set wins over release in the same cycle
    always_ff @(posedge MCLK)
    begin
      if (!RESET_N || !run)
        hold <= 1'b0;
      else if (hs_lim[i])
        hold <= 1'b1;
      else if (!ls_lim[i])
        hold <= 1'b0;
    end

    always_comb
    begin
      if (!run || hs_lim[i] || trip[i])
        next_hs = 1'b0;
      else if (start && !hold && !skip)
        next_hs = 1'b1;
      else
        next_hs = HS_ON[i];
    end

    // low side fills the rest of the period, idles while skipping unless the high side is held off
    always_ff @(posedge MCLK)
    begin
      if (!RESET_N)
      begin
        HS_ON[i] <= 1'b0;
        LS_ON[i] <= 1'b0;
      end
      else
      begin
        HS_ON[i] <= next_hs;
        LS_ON[i] <= run && !next_hs && (hold || !skip);
      end
    end

    // soft start flag from each enable rise
    always_ff @(posedge MCLK)
    begin
      if (!RESET_N || !run)
      begin
        ss_cnt        <= '0;
        SOFT_START[i] <= 1'b0;
      end
      else if (ss_cnt != meas_t'(SOFT_START_CYC))
      begin
        ss_cnt        <= ss_cnt + meas_t'(1);
        SOFT_START[i] <= (ss_cnt != meas_t'(SOFT_START_CYC - 1));
      end
    end
  end

endmodule

// ===== bench/host_model.sv
// host side of the one-pin link: open-drain driver with pull-up
`timescale 1ns/10ps
module host_model
(
  // clock and device pull-down
  input  wire logic clk,
  input  wire logic dev_oe_n,
  // resolved pin level
  output logic      line
);
  logic pull_low = 1'b0; // host pulls the pin low
  // pull-up wins unless a party pulls low; unknown enable counts as released
  assign line = !pull_low && (dev_oe_n !== 1'b0);
  // hold a level n cycles, changing just after the edge
  task hold(input logic lvl, input int n);
    @(posedge clk) #1 pull_low = !lvl;
    repeat (n - 1) @(posedge clk);
    #1;
  endtask
  // one byte; a one is short low then long high, a zero the reverse
  task send_byte(input logic [7:0] b, input int u);
    for (int i = 7; i >= 0; i--)
    begin
      hold(1'b0, b[i] ? u : 3 * u);
      hold(1'b1, b[i] ? 3 * u : u);
    end
  endtask
  // start, address, close, start, data, then close held low hold_n cycles
  task xfer(input logic [7:0] a, input logic [7:0] d, input int u, input int hold_n);
    hold(1'b1, 300);
    send_byte(a, u);
    hold(1'b0, 300);
    hold(1'b1, 300);
    send_byte(d, u);
    hold(1'b0, hold_n);
  endtask
endmodule

// ===== bench/vscale_asserts.sv
// assertion checker for the one-pin voltage scaling link
`timescale 1ns/10ps
`include "vscale_consts.svh"
module vscale_asserts #(
  parameter int MODE_TIMEOUT_CYC = 2000,
  parameter int ACK_PULSE_CYC    = 100
)
(
  // clock, reset and pin
  input wire logic       MCLK,
  input wire logic       RESET_N,
  input wire logic       MODE_DATA_IN,
  input wire logic       MODE_DATA_OE_N,
  // controls
  input wire logic       CONVERTER1_ENABLE,
  input wire logic       CONVERTER2_ENABLE,
  input wire logic       UNDER_VOLTAGE,
  input wire logic       OVER_TEMP,
  input wire logic [1:0] HS_LIMIT,
  input wire logic [1:0] LS_LIMIT,
  // outputs
  input wire logic [1:0] HS_ON,
  input wire logic [1:0] LS_ON,
  input wire logic       POWER_SAVE,
  input wire logic       RX_READY,
  input wire logic [4:0] CONVERTER1_VOLTAGE_SETTING
);
  int low_cnt; // cycles pin low, saturating so it never wraps
  int ack_cnt; // cycles of ack pull-down
  always_ff @(posedge MCLK)
    if (!RESET_N || MODE_DATA_IN) low_cnt <= 0;
    else if (low_cnt < 99999) low_cnt <= low_cnt + 1;
  always_ff @(posedge MCLK)
    if (!RESET_N || MODE_DATA_OE_N) ack_cnt <= 0;
    else ack_cnt <= ack_cnt + 1;
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESET_N);
  // both enables low long enough to pass the sync chain
  sequence s_off; (!CONVERTER1_ENABLE && !CONVERTER2_ENABLE) [*5]; endsequence
  property p_ps; $rose(POWER_SAVE) |-> low_cnt >= MODE_TIMEOUT_CYC; endproperty
  a_ps: assert property (p_ps) else $error("power save early");
  property p_pwm; MODE_DATA_IN [*4] |-> !POWER_SAVE; endproperty
  a_pwm: assert property (p_pwm) else $error("pwm not forced");
  property p_off; s_off |-> HS_ON == 2'b00 && LS_ON == 2'b00; endproperty
  a_off: assert property (p_off) else $error("switch on in shutdown");
  property p_rx; s_off |-> !RX_READY; endproperty
  a_rx: assert property (p_rx) else $error("receiver on in shutdown");
  property p_hot; OVER_TEMP [*5] |-> HS_ON == 2'b00 && LS_ON == 2'b00; endproperty
  a_hot: assert property (p_hot) else $error("switch on when hot");
  property p_uv; UNDER_VOLTAGE [*5] |-> CONVERTER1_VOLTAGE_SETTING == `SETTING1_RESET &&
    HS_ON == 2'b00 && LS_ON == 2'b00;
  endproperty
  a_uv: assert property (p_uv) else $error("lockout ignored");
  property p_lim; (HS_LIMIT[0] && LS_LIMIT[0]) [*5] |-> !HS_ON[0]; endproperty
  a_lim: assert property (p_lim) else $error("high side on in limit");
  property p_ack; $rose(MODE_DATA_OE_N) |-> ack_cnt == ACK_PULSE_CYC; endproperty
  a_ack: assert property (p_ack) else $error("ack pulse length");
endmodule
bind one_pin_vout_scaling_link vscale_asserts #(.MODE_TIMEOUT_CYC(MODE_TIMEOUT_CYC),
  .ACK_PULSE_CYC(ACK_PULSE_CYC)) u_chk (.*);

// ===== bench/testbench.sv
// self-checking bench for the one-pin voltage scaling link
`timescale 1ns/10ps
`include "vscale_consts.svh"
module testbench;
  logic       MCLK = 1'b0;
  logic       RESET_N = 1'b0;
  logic       CONVERTER1_ENABLE = 1'b0;
  logic       CONVERTER2_ENABLE = 1'b0;
  logic       UNDER_VOLTAGE = 1'b0;
  logic       OVER_TEMP = 1'b0;
  logic [1:0] HS_LIMIT = 2'b00;
  logic [1:0] LS_LIMIT = 2'b00;
  logic [1:0] PWM_TRIP = 2'b00;   // idle: full duty keeps gates easy to predict
  logic [1:0] LIGHT_LOAD = 2'b00;
  logic       MODE_DATA_IN, MODE_DATA_OUT, MODE_DATA_OE_N, POWER_SAVE, RX_READY;
  logic [1:0] HS_ON, LS_ON, SOFT_START;
  logic [4:0] CONVERTER1_VOLTAGE_SETTING, CONVERTER2_VOLTAGE_SETTING;
  int         error_cnt = 0;
  int         compares = 0;
  int         cyc = 0;
  // refused transfers: wrong address, select 01, select 11, no close
  logic [7:0] bad_a [4] = '{8'h5B, 8'h5A, 8'h5A, 8'h5A};
  logic [7:0] bad_d [4] = '{8'h9F, 8'hBF, 8'hFF, 8'h9F};
  int         bad_h [4] = '{550, 550, 550, 100};
  always #4 MCLK = ~MCLK;
  host_model host (.clk(MCLK), .dev_oe_n(MODE_DATA_OE_N), .line(MODE_DATA_IN));
  // short counts keep the run brief
  one_pin_vout_scaling_link #(.MODE_TIMEOUT_CYC(2000), .STARTUP_CYC(50),
    .ACK_PULSE_CYC(100), .SOFT_START_CYC(20)) uut (.*);
  task chk(input string n, input logic [7:0] s, input logic [7:0] e);
    compares++;
    if (s !== e)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task test_done;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // hang guard well above the expected 48k cycles
  always @(posedge MCLK)
  begin
    cyc++;
    if (cyc == 100000)
    begin
      error_cnt++;
      test_done;
    end
  end
  initial
  begin
    host.hold(1'b1, 10);
    RESET_N = 1'b1;
    chk("set1 default", CONVERTER1_VOLTAGE_SETTING, `SETTING1_RESET);
    host.xfer(8'h5A, 8'h15, 20, 300);
    chk("set1 disabled", CONVERTER1_VOLTAGE_SETTING, 8'h00);
    CONVERTER1_ENABLE = 1'b1;
    host.hold(1'b1, 5);
    chk("soft start", SOFT_START, 8'h01);
    host.hold(1'b1, 60);
    chk("rx ready", RX_READY, 8'h01);
    host.xfer(8'h5A, 8'h15, 20, 300);
    chk("set1", CONVERTER1_VOLTAGE_SETTING, 8'h15);
    // slow rate with ack request to converter 2
    host.xfer(8'h5A, 8'hCA, 400, 550);
    host.hold(1'b1, 10);
    chk("ack", MODE_DATA_IN, 8'h00);
    chk("ack level", MODE_DATA_OUT, 8'h00);
    host.hold(1'b1, 100);
    chk("ack end", MODE_DATA_IN, 8'h01);
    chk("set2", CONVERTER2_VOLTAGE_SETTING, 8'h0A);
    for (int i = 0; i < 4; i++)
    begin
      host.xfer(bad_a[i], bad_d[i], 20, bad_h[i]);
      // look where a wrongly given ack would stand, also for the cut close
      host.hold(1'b1, 560 - bad_h[i]);
      chk("no ack", MODE_DATA_IN, 8'h01);
      chk("set1 kept", CONVERTER1_VOLTAGE_SETTING, 8'h15);
      host.hold(1'b1, 700);
    end
    // light load with on-time ended: power save must idle both switches
    LIGHT_LOAD = 2'b01;
    PWM_TRIP = 2'b01;
    host.hold(1'b0, 2100);
    chk("power save", POWER_SAVE, 8'h01);
    chk("pfm idle", {HS_ON[0], LS_ON[0]}, 8'h00);
    host.hold(1'b1, 4);
    chk("forced pwm", POWER_SAVE, 8'h00);
    LIGHT_LOAD = 2'b00;
    PWM_TRIP = 2'b00;
    CONVERTER2_ENABLE = 1'b1;
    HS_LIMIT = 2'b11;
    LS_LIMIT = 2'b11;
    host.hold(1'b1, 100);
    chk("limit", {HS_ON, LS_ON}, 8'h03);
    // high side stays barred while the low side is still over its limit
    HS_LIMIT = 2'b00;
    host.hold(1'b1, 60);
    chk("limit hold", {HS_ON, LS_ON}, 8'h03);
    LS_LIMIT = 2'b00;
    OVER_TEMP = 1'b1;
    host.hold(1'b1, 10);
    chk("hot", {HS_ON, LS_ON}, 8'h00);
    OVER_TEMP = 1'b0;
    host.hold(1'b1, 10);
    chk("resume", HS_ON | LS_ON, 8'h03);
    CONVERTER1_ENABLE = 1'b0;
    CONVERTER2_ENABLE = 1'b0;
    host.hold(1'b1, 10);
    chk("retained", CONVERTER1_VOLTAGE_SETTING, 8'h15);
    UNDER_VOLTAGE = 1'b1;
    CONVERTER1_ENABLE = 1'b1; // lockout must keep it from starting
    host.hold(1'b1, 10);
    chk("lockout", CONVERTER2_VOLTAGE_SETTING, `SETTING2_RESET);
    chk("lockout off", {HS_ON, LS_ON, RX_READY}, 8'h00);
    test_done;
  end
endmodule
